// ### logic/qdac_core.sv
`timescale 1ns/1ps
`default_nettype none
module qdac_core #(
    parameter int CODE_W = qdac_pkg::CODE_BITS
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               sclk_i,
    input  wire logic               sync_n_i,
    input  wire logic               din_i,
    input  wire logic               low_supply_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [31:0]        wb_dat_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic               wb_we_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    output logic [31:0]             wb_dat_o,
    output logic                    wb_ack_o,
    output logic                    wb_err_o,
    output logic [4*CODE_W-1:0]     conv_code_o,
    output logic [3:0]              out_en_o,
    output logic                    analog_on_o
);
    typedef struct packed {
        logic [2:0]               tgl_sync;
        logic [15:0]              word_a;
        logic [2:0]               supply_sync;
        logic                     low_supply;
        logic [3:0][CODE_W-1:0]   input_reg;
        logic [3:0][CODE_W-1:0]   conv_reg;
        logic [3:0]               changed;
        logic                     power_on;
        logic                     outputs_live;
        logic [7:0]               wake_cnt;
        logic [7:0]               frames;
        logic                     enable;
        logic [31:0]              dat;
        logic                     ack;
        logic                     err;
    } qdac_core_type;

    qdac_core_type st;
    qdac_core_type next_st;

    logic [15:0] link_word;
    logic        link_tgl;

    qdac_link u_link (
        .sclk_i     (sclk_i),
        .sync_n_i   (sync_n_i),
        .din_i      (din_i),
        .word_o     (link_word),
        .done_tgl_o (link_tgl)
    );

    function automatic logic [1:0] ch_of(input logic [15:0] w);
        ch_of = {w[qdac_pkg::SEL_HI_POS], w[qdac_pkg::SEL_LO_POS]};
    endfunction : ch_of

    function automatic logic [CODE_W-1:0] code_of(input logic [15:0] w);
        code_of = w[qdac_pkg::CODE_MSB_POS -: CODE_W];
    endfunction : code_of

    logic        frame_done;
    logic [15:0] rx;
    logic [1:0]  rx_ch;
    logic        rx_load;
    logic        rx_power;
    logic        wb_req;
    logic [7:0]  wake_target;

    always_comb begin
        // Word taken a cycle after the toggle arrived, so it has settled
        frame_done  = (st.tgl_sync[2] != st.tgl_sync[1]) && st.enable;
        rx          = st.word_a;
        rx_ch       = ch_of(rx);
        rx_load     = rx[qdac_pkg::LOAD_ALL_POS];
        rx_power    = rx[qdac_pkg::POWER_POS];
        wb_req      = wb_cyc_i && wb_stb_i && !st.ack && !st.err;
        wake_target = st.low_supply ? 8'(qdac_pkg::WAKE_CYC_3V) : 8'(qdac_pkg::WAKE_CYC_5V);

        next_st          = st;
        next_st.tgl_sync = {st.tgl_sync[1:0], link_tgl};
        next_st.word_a   = link_word;
        next_st.supply_sync = {st.supply_sync[1:0], low_supply_i};
        if (st.supply_sync[2] == st.supply_sync[1]) begin
            next_st.low_supply = st.supply_sync[2];
        end
        next_st.ack      = 1'b0;
        next_st.err      = 1'b0;

        if (frame_done) begin
            next_st.frames = st.frames + 8'd1;
            next_st.input_reg[rx_ch] = code_of(rx);
            next_st.changed[rx_ch]   = 1'b1;
            if (!rx_load) begin
                for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
                    if (next_st.changed[i]) begin
                        next_st.conv_reg[i] = next_st.input_reg[i];
                        next_st.changed[i]  = 1'b0;
                    end
                end
            end
            next_st.power_on = rx_power;
            if (!rx_power) begin
                next_st.outputs_live = 1'b0;
                next_st.wake_cnt     = 8'd0;
            end else if (!st.power_on) begin
                next_st.wake_cnt = 8'd1;
            end
        end else if (st.power_on && !st.outputs_live) begin
            if (st.wake_cnt >= wake_target) begin
                next_st.outputs_live = 1'b1;
            end else begin
                next_st.wake_cnt = st.wake_cnt + 8'd1;
            end
        end

        if (wb_req) begin
            next_st.ack = 1'b1;
            next_st.dat = 32'h0000_0000;
            case (wb_adr_i)
                qdac_pkg::ADR_CONV0:  next_st.dat[CODE_W-1:0] = st.conv_reg[0];
                qdac_pkg::ADR_CONV1:  next_st.dat[CODE_W-1:0] = st.conv_reg[1];
                qdac_pkg::ADR_CONV2:  next_st.dat[CODE_W-1:0] = st.conv_reg[2];
                qdac_pkg::ADR_CONV3:  next_st.dat[CODE_W-1:0] = st.conv_reg[3];
                qdac_pkg::ADR_INPUT0: next_st.dat[CODE_W-1:0] = st.input_reg[0];
                qdac_pkg::ADR_INPUT1: next_st.dat[CODE_W-1:0] = st.input_reg[1];
                qdac_pkg::ADR_INPUT2: next_st.dat[CODE_W-1:0] = st.input_reg[2];
                qdac_pkg::ADR_INPUT3: next_st.dat[CODE_W-1:0] = st.input_reg[3];
                qdac_pkg::ADR_STATUS: begin
                    next_st.dat[qdac_pkg::STATUS_POWER_POS]        = st.outputs_live;
                    next_st.dat[qdac_pkg::STATUS_CHANGED_POS +: 4] = st.changed;
                    next_st.dat[qdac_pkg::STATUS_FRAMES_POS +: 8]  = st.frames;
                end
                qdac_pkg::ADR_CTRL: begin
                    next_st.dat[qdac_pkg::CTRL_ENABLE_POS] = st.enable;
                    if (wb_we_i && wb_sel_i[0]) begin
                        next_st.enable = wb_dat_i[qdac_pkg::CTRL_ENABLE_POS];
                    end
                end
                default: begin
                    next_st.ack = 1'b0;
                    next_st.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st              <= '0;
            st.power_on     <= qdac_pkg::POWER_RESET;
            st.outputs_live <= qdac_pkg::POWER_RESET;
            st.enable       <= qdac_pkg::CTRL_ENABLE_RESET;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
            conv_code_o[i*CODE_W +: CODE_W] = st.conv_reg[i];
        end
    end
    assign out_en_o    = {4{st.outputs_live}};
    assign analog_on_o = st.power_on;
    assign wb_dat_o    = st.dat;
    assign wb_ack_o    = st.ack;
    assign wb_err_o    = st.err;

    property p_hold_on_load_high;
        @(posedge clk_i) disable iff (rst_i)
        (frame_done && rx_load) |=> $stable(st.conv_reg);
    endproperty
    a_hold_on_load_high: assert property (p_hold_on_load_high) else $error("converter changed with load high");

    property p_input_written;
        @(posedge clk_i) disable iff (rst_i)
        frame_done |=> st.input_reg[$past(rx_ch)] == code_of($past(rx));
    endproperty
    a_input_written: assert property (p_input_written) else $error("input register not written");

    property p_update_all;
        @(posedge clk_i) disable iff (rst_i)
        (frame_done && !rx_load) |=> (st.changed == 4'h0);
    endproperty
    a_update_all: assert property (p_update_all) else $error("changed flags left after update");

    property p_no_spurious_conv;
        @(posedge clk_i) disable iff (rst_i)
        !frame_done |=> $stable(st.conv_reg);
    endproperty
    a_no_spurious_conv: assert property (p_no_spurious_conv) else $error("converter changed without frame");

    property p_unchanged_kept;
        @(posedge clk_i) disable iff (rst_i)
        (frame_done && !rx_load && !st.changed[0] && rx_ch != 2'd0) |=> $stable(st.conv_reg[0]);
    endproperty
    a_unchanged_kept: assert property (p_unchanged_kept) else $error("unchanged channel reloaded");

    property p_power_down;
        @(posedge clk_i) disable iff (rst_i)
        (frame_done && !rx_power) |=> (out_en_o == 4'h0 && !analog_on_o);
    endproperty
    a_power_down: assert property (p_power_down) else $error("outputs not released");

    property p_wake_bound;
        @(posedge clk_i) disable iff (rst_i)
        $rose(st.power_on) |-> ##[1:60] st.outputs_live;
    endproperty
    a_wake_bound: assert property (p_wake_bound) else $error("wake too slow");

    property p_changed_set;
        @(posedge clk_i) disable iff (rst_i)
        (frame_done && rx_load) |=> st.changed[$past(rx_ch)];
    endproperty
    a_changed_set: assert property (p_changed_set) else $error("changed flag not set");

    property p_wb_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_wb_ack_once: assert property (p_wb_ack_once) else $error("ack held too long");

    property p_wb_answer;
        @(posedge clk_i) disable iff (rst_i)
        wb_req |=> (wb_ack_o != wb_err_o);
    endproperty
    a_wb_answer: assert property (p_wb_answer) else $error("request not answered");

    property p_wb_quiet;
        @(posedge clk_i) disable iff (rst_i)
        !wb_req |=> (!wb_ack_o && !wb_err_o);
    endproperty
    a_wb_quiet: assert property (p_wb_quiet) else $error("answer without request");

    property p_wb_unmapped;
        @(posedge clk_i) disable iff (rst_i)
        (wb_req && wb_adr_i > qdac_pkg::ADR_CTRL) |=> wb_err_o;
    endproperty
    a_wb_unmapped: assert property (p_wb_unmapped) else $error("unmapped address not refused");

    property p_disabled_drop;
        @(posedge clk_i) disable iff (rst_i)
        (st.tgl_sync[2] != st.tgl_sync[1] && !st.enable) |=> $stable(st.input_reg);
    endproperty
    a_disabled_drop: assert property (p_disabled_drop) else $error("frame taken while disabled");

    property p_asleep_dark;
        @(posedge clk_i) disable iff (rst_i)
        !analog_on_o |-> (out_en_o == 4'h0);
    endproperty
    a_asleep_dark: assert property (p_asleep_dark) else $error("output driven while asleep");

    property p_wake_not_early;
        @(posedge clk_i) disable iff (rst_i)
        $rose(st.power_on) |-> (!st.outputs_live) [*8];
    endproperty
    a_wake_not_early: assert property (p_wake_not_early) else $error("outputs woke too early");

    property p_asleep_kept;
        @(posedge clk_i) disable iff (rst_i)
        (!st.power_on && !frame_done) |=> ($stable(st.input_reg) && $stable(st.conv_reg));
    endproperty
    a_asleep_kept: assert property (p_asleep_kept) else $error("registers changed while asleep");

    property p_reset_state;
        @(posedge clk_i)
        rst_i |=> (st.input_reg == '0 && st.conv_reg == '0 && out_en_o == 4'hf && analog_on_o);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    property p_frame_count;
        @(posedge clk_i) disable iff (rst_i)
        frame_done |=> (st.frames == $past(st.frames) + 8'd1);
    endproperty
    a_frame_count: assert property (p_frame_count) else $error("frame count not advanced");

    c_frame: cover property (@(posedge clk_i) disable iff (rst_i) frame_done && rx_load);
    c_update: cover property (@(posedge clk_i) disable iff (rst_i) frame_done && !rx_load);
    c_pd: cover property (@(posedge clk_i) disable iff (rst_i) frame_done && !rx_power);
    c_wake: cover property (@(posedge clk_i) disable iff (rst_i) $rose(st.outputs_live));
endmodule : qdac_core
`default_nettype wire

// ### logic/qdac_pkg.sv
package qdac_pkg;
    localparam int FRAME_BITS    = 16;
    localparam int CODE_BITS     = 12;
    localparam int NUM_CH        = 4;
    localparam int CH_BITS       = 2;
    localparam int SEL_HI_POS    = 15;
    localparam int SEL_LO_POS    = 14;
    localparam int POWER_POS     = 13;
    localparam int LOAD_ALL_POS  = 12;
    localparam int CODE_MSB_POS  = 11;
    localparam logic [11:0] CODE_RESET  = 12'h000;
    localparam logic        POWER_RESET = 1'b1;
    // Wishbone byte addresses
    localparam logic [7:0] ADR_CONV0  = 8'h00;
    localparam logic [7:0] ADR_CONV1  = 8'h04;
    localparam logic [7:0] ADR_CONV2  = 8'h08;
    localparam logic [7:0] ADR_CONV3  = 8'h0c;
    localparam logic [7:0] ADR_INPUT0 = 8'h10;
    localparam logic [7:0] ADR_INPUT1 = 8'h14;
    localparam logic [7:0] ADR_INPUT2 = 8'h18;
    localparam logic [7:0] ADR_INPUT3 = 8'h1c;
    localparam logic [7:0] ADR_STATUS = 8'h20;
    localparam logic [7:0] ADR_CTRL   = 8'h24;
    localparam int STATUS_POWER_POS   = 0;
    localparam int STATUS_CHANGED_POS = 4;
    localparam int STATUS_FRAMES_POS  = 8;
    localparam int FRAME_CNT_BITS     = 8;
    localparam int CTRL_ENABLE_POS    = 0;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam int CLK_HZ = 10_000_000;
    localparam real WAKE_US_5V = 2.5;
    localparam real WAKE_US_3V = 5.0;
    localparam int WAKE_CYC_5V = int'((WAKE_US_5V * CLK_HZ) / 1.0e6);
    localparam int WAKE_CYC_3V = int'((WAKE_US_3V * CLK_HZ) / 1.0e6);
    localparam int WAKE_CNT_BITS = 8;
endpackage : qdac_pkg

// ### logic/qdac_link.sv
`timescale 1ns/1ps
`default_nettype none
// Serial side: runs on the serial clock, captures on its falling edge
module qdac_link (
    input  wire logic        sclk_i,
    input  wire logic        sync_n_i,
    input  wire logic        din_i,
    output logic [15:0]      word_o,
    output logic             done_tgl_o
);
    typedef struct packed {
        logic [15:0] shift;
        logic [15:0] word;
        logic        tgl;
    } qdac_link_type;

    // Power-on state only; there is no reset pin on this side
    qdac_link_type st = '0;
    qdac_link_type next_st;
    logic [4:0]    count = 5'd0;
    logic [4:0]    next_count;

    always_comb begin
        next_st    = st;
        next_count = count;
        if (count < 5'(qdac_pkg::FRAME_BITS)) begin
            next_st.shift = {st.shift[14:0], din_i};
            next_count    = count + 5'd1;
            if (count == 5'(qdac_pkg::FRAME_BITS - 1)) begin
                next_st.word = {st.shift[14:0], din_i};
                next_st.tgl  = ~st.tgl;
            end
        end
    end

    // Frame select high clears the bit count; an early rise aborts
    always_ff @(negedge sclk_i or posedge sync_n_i) begin
        if (sync_n_i) begin
            count <= 5'd0;
        end else begin
            count <= next_count;
        end
    end

    // Data only shifts while the frame is open
    always_ff @(negedge sclk_i) begin
        if (!sync_n_i) begin
            st <= next_st;
        end
    end

    assign word_o     = st.word;
    assign done_tgl_o = st.tgl;
endmodule : qdac_link
`default_nettype wire

// ### tb/qdac_host.sv
`timescale 1ns/1ps
`default_nettype none
// Serial controller; its clock stands still between frames
module qdac_host (
    output logic sclk_o,
    output logic sync_n_o,
    output logic din_o
);
    logic lclk = 1'b0;
    initial begin
        #1.3;
        forever #3 lclk = ~lclk;
    end
    initial begin
        sclk_o = 1'b0;
        sync_n_o = 1'b1;
        din_o = 1'b0;
    end
    // Sends n bits from bit 31 down; fewer than 16 aborts the frame
    task automatic send(input logic [31:0] w, input int n);
        @(posedge lclk) sync_n_o <= 1'b0;
        for (int i = 0; i < n; i++) begin
            if (i == 8 && n == 16) repeat (4) @(posedge lclk);
            @(posedge lclk) sclk_o <= 1'b1;
            din_o <= w[31 - i];
            @(negedge lclk) sclk_o <= 1'b0;
        end
        @(posedge lclk) sync_n_o <= 1'b1;
        din_o <= ~din_o;
    endtask : send
endmodule : qdac_host
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        sclk, sync_n, din, errf;
    logic        low_supply_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0]  wb_sel_i = 4'hf, out_en_o;
    logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic        wb_ack_o, wb_err_o, analog_on_o;
    logic [47:0] conv_code_o;
    logic [11:0] inp [4], conv [4];
    logic [3:0]  chg;
    logic        en = 1'b1;
    int          error_cnt = 0, n_tests = 0, seed = 78, wake;
    initial forever #50 clk_i = ~clk_i;
    qdac_host host (.sclk_o(sclk), .sync_n_o(sync_n), .din_o(din));
    qdac_core uut (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .sync_n_i(sync_n), .din_i(din),
        .low_supply_i(low_supply_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .conv_code_o(conv_code_o), .out_en_o(out_en_o),
        .analog_on_o(analog_on_o));
    task automatic cmp(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : cmp
    task automatic print_verdict();
        $display("errors=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
        int k;
        k = 0;
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 50);
        rd = wb_dat_o;
        errf = wb_err_o;
        cmp(48'(wb_ack_o | wb_err_o), 48'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // Sends one frame and applies it to the reference model when at least 16 bits go out and the core is enabled
    task automatic frame(input logic [1:0] ch, input logic p, input logic ld, input int n);
        logic [11:0] c;
        c = 12'($random(seed));
        host.send({ch, p, ld, c, 16'h5a5a}, n);
        if (n >= 16 && en) begin
            inp[ch] = c;
            chg[ch] = 1'b1;
            for (int i = 0; i < 4; i++) begin
                if (!ld && chg[i]) begin
                    conv[i] = inp[i];
                    chg[i] = 1'b0;
                end
            end
        end
        repeat (10) @(posedge clk_i);
    endtask : frame
    task automatic check_all();
        cmp(conv_code_o, {conv[3], conv[2], conv[1], conv[0]});
        for (int i = 0; i < 4; i++) begin
            wb(qdac_pkg::ADR_INPUT0 + 8'(4 * i), 1'b0, 32'h0);
            cmp(48'(rd[11:0]), 48'(inp[i]));
            wb(qdac_pkg::ADR_CONV0 + 8'(4 * i), 1'b0, 32'h0);
            cmp(48'(rd[11:0]), 48'(conv[i]));
        end
        wb(qdac_pkg::ADR_STATUS, 1'b0, 32'h0);
        cmp(48'(rd[7:4]), 48'(chg));
    endtask : check_all
    initial begin
        for (int i = 0; i < 4; i++) begin
            inp[i] = 12'h000;
            conv[i] = 12'h000;
        end
        chg = 4'h0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        cmp(48'(out_en_o), 48'(4'hf));
        check_all();
        wb(qdac_pkg::ADR_CTRL, 1'b0, 32'h0);
        cmp(48'(rd[0]), 48'(1'b1));
        for (int i = 0; i < 3; i++) begin
            frame(2'(i), 1'b1, 1'b1, 16);
            check_all();
        end
        frame(2'h3, 1'b1, 1'b0, 16);
        check_all();
        frame(2'h0, 1'b1, 1'b1, 16);
        frame(2'h2, 1'b1, 1'b0, 16);
        check_all();
        frame(2'h1, 1'b1, 1'b0, 10);
        check_all();
        frame(2'h1, 1'b1, 1'b0, 24);
        check_all();
        for (int s = 0; s < 2; s++) begin
            low_supply_i <= 1'(s);
            wake = s ? qdac_pkg::WAKE_CYC_3V : qdac_pkg::WAKE_CYC_5V;
            frame(2'($random(seed)), 1'b0, 1'b1, 16);
            cmp(48'({out_en_o, analog_on_o}), 48'h0);
            check_all();
            frame(2'($random(seed)), 1'b1, 1'b0, 16);
            cmp(48'(analog_on_o), 48'h1);
            repeat (wake - 15) @(posedge clk_i);
            cmp(48'(out_en_o), 48'h0);
            repeat (20) @(posedge clk_i);
            cmp(48'(out_en_o), 48'hf);
        end
        wb(qdac_pkg::ADR_CTRL, 1'b1, 32'h0);
        en = 1'b0;
        frame(2'h2, 1'b1, 1'b0, 16);
        check_all();
        wb(qdac_pkg::ADR_CTRL, 1'b1, 32'h1);
        en = 1'b1;
        frame(2'h3, 1'b1, 1'b0, 16);
        check_all();
        wb(8'h28, 1'b0, 32'h0);
        cmp(48'(errf), 48'h1);
        print_verdict();
    end
    initial begin
        repeat (8000) @(posedge clk_i);
        error_cnt++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
